// file: design/derq_arbiter.sv
`timescale 1ns/100ps
module derq_arbiter (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  transfer_request_in_n,
    output logic                       transfer_ack_out_n,
    output logic                       bus_clear_out_n,
    output logic                       bus_request_line_n,
    input  wire derq_pkg::derq_arb_in_t arb_in,
    input  wire derq_pkg::derq_cyc_t   cyc_in,
    input  wire logic                  pack_drain_need,
    input  wire logic                  limited_slot,
    output logic                       module_bus_req,
    output logic                       cycle_start,
    output logic                       cycle_write
);
    logic [31:0]                mode_reg;
    logic [31:0]                config_reg;
    derq_pkg::derq_state_t      state_reg;
    derq_pkg::derq_state_t      state_next;
    logic                       req_sync;
    logic                       req_eff;
    logic                       req_prev_reg;
    logic                       pending_reg;
    logic                       continue_reg;
    logic                       extra_reg;
    logic                       bclr_reg;
    logic                       ack_reg;
    logic                       in_cycle_reg;
    logic                       started;
    logic                       steal_edge;
    logic                       want_bus;
    logic                       granted;
    logic                       periph_cycle;
    logic                       is_write_next;
    logic [2:0]                 my_id;
    logic [2:0]                 interrupt_service_mask;
    logic [2:0]                 bclr_thr;
    logic                       side_sel;
    logic                       packing;
    logic                       dual;
    derq_pkg::derq_req_mode_t   req_mode;
    logic                       apb_wr;

    assign started  = mode_reg[derq_pkg::START_BIT];
    assign side_sel = mode_reg[derq_pkg::SIDE_SEL_BIT];
    assign packing  = mode_reg[derq_pkg::PACK_BIT];
    assign dual     = mode_reg[derq_pkg::DUAL_ADDR_BIT];
    assign req_mode = derq_pkg::derq_req_mode_t'(mode_reg[derq_pkg::REQ_MODE_LSB +: 2]);
    assign my_id    = config_reg[derq_pkg::ARB_ID_LSB +: 3];
    assign interrupt_service_mask      = config_reg[derq_pkg::ISM_LSB +: 3];
    assign bclr_thr = config_reg[derq_pkg::BCLR_ID_LSB +: 3];

    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign apb_wr  = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= derq_pkg::CHAN_MODE_RST;
        end else if (apb_wr && paddr == derq_pkg::CHAN_MODE_OFF) begin
            mode_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= derq_pkg::CHAN_CONFIG_RST;
        end else if (apb_wr && paddr == derq_pkg::CHAN_CONFIG_OFF) begin
            config_reg <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                derq_pkg::CHAN_MODE_OFF:   prdata <= mode_reg;
                derq_pkg::CHAN_CONFIG_OFF: prdata <= config_reg;
                derq_pkg::STATUS_OFF: begin
                    prdata <= {24'h00_0000, pending_reg, bclr_reg, ack_reg,
                               state_reg, req_eff, continue_reg};
                end
                default:                   prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Optional request synchronizer
    derq_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (transfer_request_in_n),
        .q       (req_sync)
    );

    // Active-low request, selected path, gated by start
    assign req_eff = started && !(mode_reg[derq_pkg::SYNC_REQ_BIT] ? transfer_request_in_n
                                                                   : req_sync);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_prev_reg <= 1'b0;
        end else begin
            req_prev_reg <= req_eff;
        end
    end

    assign steal_edge = req_eff && !req_prev_reg;

    // Peripheral cycle: read when peripheral is source, write otherwise
    // Single address: the only cycle of an operand always touches the peripheral
    assign periph_cycle = (state_reg == derq_pkg::DERQ_RD) ? (side_sel || !dual)
                        : (state_reg == derq_pkg::DERQ_WR) ? !side_sel
                        : 1'b0;

    // Steal pending flag: set wins, further edges ignored while pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= 1'b0;
        end else if (!started) begin
            pending_reg <= 1'b0;
        end else if (req_mode == derq_pkg::DERQ_EXT_STEAL) begin
            if (steal_edge) begin
                pending_reg <= 1'b1;
            end else if (state_reg == derq_pkg::DERQ_ARB && granted) begin
                pending_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        case (req_mode)
            derq_pkg::DERQ_INT_MAX:   want_bus = started;
            derq_pkg::DERQ_INT_LIM:   want_bus = started && limited_slot;
            derq_pkg::DERQ_EXT_BURST: want_bus = req_eff;
            derq_pkg::DERQ_EXT_STEAL: want_bus = pending_reg;
            default:                  want_bus = 1'b0;
        endcase
    end

    // Per-cycle priority and interrupt gate
    assign granted = !arb_in.ext_master_req
                  && (!arb_in.other_req || my_id > arb_in.other_id)
                  && (arb_in.int_level <= interrupt_service_mask);

    assign module_bus_req = (state_reg == derq_pkg::DERQ_ARB);
    assign bus_request_line_n = 1'b1;

    // Decision at last S3 fall of the peripheral cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            continue_reg <= 1'b0;
            extra_reg    <= 1'b0;
        end else if (state_reg == derq_pkg::DERQ_ARB) begin
            continue_reg <= 1'b1;
            extra_reg    <= 1'b0;
        end else if (periph_cycle && cyc_in.s3_fall) begin
            if (req_mode == derq_pkg::DERQ_EXT_BURST) begin
                continue_reg <= req_eff;
                extra_reg    <= req_eff && !packing && cyc_in.fast_term;
            end else if (req_mode == derq_pkg::DERQ_EXT_STEAL) begin
                continue_reg <= req_eff && !req_prev_reg || steal_edge;
                extra_reg    <= 1'b0;
            end
        end else if (periph_cycle && cyc_in.cycle_done && extra_reg) begin
            extra_reg <= 1'b0;
        end
    end

    always_comb begin
        if (!dual) begin
            is_write_next = !side_sel;
        end else begin
            is_write_next = (state_reg == derq_pkg::DERQ_RD);
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            derq_pkg::DERQ_IDLE: begin
                if (want_bus) begin
                    state_next = derq_pkg::DERQ_ARB;
                end
            end
            derq_pkg::DERQ_ARB: begin
                if (!want_bus && req_mode == derq_pkg::DERQ_EXT_BURST) begin
                    state_next = derq_pkg::DERQ_IDLE;
                end else if (granted) begin
                    state_next = derq_pkg::DERQ_RD;
                end
            end
            derq_pkg::DERQ_RD: begin
                if (cyc_in.cycle_done) begin
                    if (dual) begin
                        state_next = derq_pkg::DERQ_WR;
                    end else if (periph_cycle && !continue_reg && !extra_reg) begin
                        state_next = derq_pkg::DERQ_REL;
                    end else if (!started) begin
                        state_next = derq_pkg::DERQ_REL;
                    end else begin
                        state_next = derq_pkg::DERQ_RD;
                    end
                end
            end
            derq_pkg::DERQ_WR: begin
                if (cyc_in.cycle_done) begin
                    if (req_mode == derq_pkg::DERQ_EXT_STEAL) begin
                        state_next = continue_reg ? derq_pkg::DERQ_RD
                                                  : derq_pkg::DERQ_REL;
                    end else if (!started) begin
                        state_next = derq_pkg::DERQ_REL;
                    end else if (!continue_reg && !extra_reg) begin
                        state_next = derq_pkg::DERQ_REL;
                    end else begin
                        state_next = derq_pkg::DERQ_RD;
                    end
                end
            end
            derq_pkg::DERQ_DRAIN: begin
                if (cyc_in.cycle_done) begin
                    state_next = derq_pkg::DERQ_REL;
                end
            end
            derq_pkg::DERQ_REL: begin
                state_next = derq_pkg::DERQ_IDLE;
            end
            default: state_next = derq_pkg::DERQ_IDLE;
        endcase
        // Packing with peripheral source, single address only: drain buffer before release
        if (packing && side_sel && state_next == derq_pkg::DERQ_REL
            && state_reg == derq_pkg::DERQ_RD && pack_drain_need) begin
            state_next = derq_pkg::DERQ_DRAIN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= derq_pkg::DERQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_cycle_reg <= 1'b0;
        end else begin
            in_cycle_reg <= (state_next == derq_pkg::DERQ_RD
                          || state_next == derq_pkg::DERQ_WR
                          || state_next == derq_pkg::DERQ_DRAIN)
                          && !cyc_in.cycle_done;
        end
    end

    assign cycle_start = (state_next == derq_pkg::DERQ_RD || state_next == derq_pkg::DERQ_WR
                       || state_next == derq_pkg::DERQ_DRAIN)
                       && (state_next != state_reg || cyc_in.cycle_done);
    assign cycle_write = (state_next == derq_pkg::DERQ_DRAIN) || is_write_next;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= periph_cycle && !cyc_in.cycle_done;
        end
    end

    // Bus clear: held while requesting/owning, dropped in S2 of a final peripheral cycle, otherwise once back in idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclr_reg <= 1'b0;
        end else if (config_reg[derq_pkg::CORE_EN_BIT] && my_id > bclr_thr
                     && state_reg == derq_pkg::DERQ_ARB) begin
            bclr_reg <= 1'b1;
        end else if (cyc_in.s2 && (state_next == derq_pkg::DERQ_REL
                     || (!continue_reg && !extra_reg && periph_cycle))) begin
            bclr_reg <= 1'b0;
        end else if (state_reg == derq_pkg::DERQ_IDLE) begin
            bclr_reg <= 1'b0;
        end
    end

    assign transfer_ack_out_n = !ack_reg;
    assign bus_clear_out_n    = !bclr_reg;

    a_ack_only_periph: assert property (@(posedge pclk) disable iff (!presetn)
        !transfer_ack_out_n |-> $past(periph_cycle))
        else $error("ack without peripheral cycle");
    a_ignore_unstarted: assert property (@(posedge pclk) disable iff (!presetn)
        !started |-> ##1 !pending_reg)
        else $error("request acted on while stopped");
    a_steal_pending: assert property (@(posedge pclk) disable iff (!presetn)
        pending_reg && state_reg != derq_pkg::DERQ_ARB && started |=> pending_reg)
        else $error("pending request lost");
    a_bus_req_lines: assert property (@(posedge pclk) disable iff (!presetn)
        bus_request_line_n)
        else $error("external bus request touched");
    a_bclr_threshold: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(bclr_reg) |-> $past(my_id > bclr_thr))
        else $error("bus clear below threshold");
    a_grant_mask: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == derq_pkg::DERQ_ARB && state_next == derq_pkg::DERQ_RD
        |-> arb_in.int_level <= interrupt_service_mask)
        else $error("bus taken above mask");
    a_arb_on_request: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == derq_pkg::DERQ_IDLE && want_bus |=> module_bus_req)
        else $error("no arbitration on request");
    a_grant_priority: assert property (@(posedge pclk) disable iff (!presetn)
        module_bus_req && arb_in.ext_master_req |=> state_reg != derq_pkg::DERQ_RD)
        else $error("granted over external master");
    a_burst_stop: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == derq_pkg::DERQ_WR && cyc_in.cycle_done && !continue_reg && !extra_reg
        && req_mode == derq_pkg::DERQ_EXT_BURST && started
        |=> state_reg == derq_pkg::DERQ_REL)
        else $error("burst did not stop");
    a_edge_pend: assert property (@(posedge pclk) disable iff (!presetn)
        started && steal_edge && req_mode == derq_pkg::DERQ_EXT_STEAL |=> pending_reg)
        else $error("edge not registered");

    c_burst:   cover property (@(posedge pclk) disable iff (!presetn)
        req_mode == derq_pkg::DERQ_EXT_BURST && !transfer_ack_out_n);
    c_steal:   cover property (@(posedge pclk) disable iff (!presetn)
        pending_reg ##1 module_bus_req);
    c_drain:   cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == derq_pkg::DERQ_DRAIN);
    c_bclr:    cover property (@(posedge pclk) disable iff (!presetn)
        !bus_clear_out_n);
endmodule

// file: design/derq_pkg.sv
package derq_pkg;

    // Register byte offsets
    localparam logic [11:0] CHAN_MODE_OFF   = 12'h000;
    localparam logic [11:0] CHAN_CONFIG_OFF = 12'h004;
    localparam logic [11:0] ARB_CTRL_OFF    = 12'h008;
    localparam logic [11:0] STATUS_OFF      = 12'h00c;

    // Channel mode register fields
    localparam int START_BIT     = 0;
    localparam int SIDE_SEL_BIT  = 1;
    localparam int SYNC_REQ_BIT  = 2;
    localparam int REQ_MODE_LSB  = 3;
    localparam int PACK_BIT      = 5;
    localparam int DUAL_ADDR_BIT = 6;

    // Channel config register fields
    localparam int ARB_ID_LSB    = 0;
    localparam int ISM_LSB       = 4;
    localparam int BCLR_ID_LSB   = 8;
    localparam int CORE_EN_BIT   = 12;

    // Reset values
    localparam logic [31:0] CHAN_MODE_RST   = 32'h0000_0000;
    localparam logic [31:0] CHAN_CONFIG_RST = 32'h0000_1000;

    // Bus cycle length with no wait state, in clocks (S0..S5 pairs)
    localparam logic [2:0] CYCLE_CLKS = 3'h3;

    typedef enum logic [1:0] {
        DERQ_INT_MAX   = 2'h0,
        DERQ_INT_LIM   = 2'h1,
        DERQ_EXT_BURST = 2'h2,
        DERQ_EXT_STEAL = 2'h3
    } derq_req_mode_t;

    // Gray coded bus-cycle states along idle-arb-read-write path
    typedef enum logic [2:0] {
        DERQ_IDLE  = 3'b000,
        DERQ_ARB   = 3'b001,
        DERQ_RD    = 3'b011,
        DERQ_WR    = 3'b010,
        DERQ_DRAIN = 3'b110,
        DERQ_REL   = 3'b111
    } derq_state_t;

    // Arbitration view of the internal module bus
    typedef struct packed {
        logic       other_req;
        logic [2:0] other_id;
        logic       ext_master_req;
        logic [2:0] int_level;
    } derq_arb_in_t;

    // Bus cycle status from the bus cycle engine
    typedef struct packed {
        logic s3_fall;
        logic s2;
        logic cycle_done;
        logic fast_term;
    } derq_cyc_t;

endpackage

// file: design/derq_sync.sv
`timescale 1ns/100ps
module derq_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b1;
            q        <= 1'b1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// file: tb/derq_arbiter_bench.sv
`timescale 1ns/100ps
module derq_arbiter_bench;
    logic                  pclk = 1'b0;
    logic                  presetn = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0000_0000;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  req_n;
    logic                  ack_n;
    logic                  bclr_n;
    logic                  breq_n;
    derq_pkg::derq_arb_in_t arb = '0;
    derq_pkg::derq_cyc_t   cyc = '0;
    logic                  mb_req;
    logic                  cyc_start;
    logic                  cyc_wr;
    logic                  burst_go = 1'b0;
    logic                  pulse_go = 1'b0;
    logic [3:0]            blen = 4'h3;
    logic [2:0]            ecnt = 3'h0;
    logic                  ack_q = 1'b1;
    logic                  bclr_seen = 1'b0;
    logic [31:0]           rd;
    int                    n_ack = 0;
    int                    errors = 0;
    int                    n_tests = 0;
    int                    cycles = 0;

    initial forever #20 pclk = ~pclk;

    derq_arbiter derq_arbiter_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .transfer_request_in_n(req_n), .transfer_ack_out_n(ack_n),
        .bus_clear_out_n(bclr_n), .bus_request_line_n(breq_n), .arb_in(arb),
        .cyc_in(cyc), .pack_drain_need(1'b0), .limited_slot(1'b0),
        .module_bus_req(mb_req), .cycle_start(cyc_start), .cycle_write(cyc_wr));

    derq_periph derq_periph_inst (.pclk(pclk), .presetn(presetn), .ack_n(ack_n),
        .burst_go(burst_go), .pulse_go(pulse_go), .burst_len(blen), .req_n(req_n));

    // Bus cycle engine: S2 then S3 fall then completion, three clocks per cycle
    always @(posedge pclk) begin
        // A new cycle may start in the completing clock of the previous one
        cyc.s2         <= ((ecnt == 3'h0 || ecnt == 3'h3) && cyc_start === 1'b1);
        cyc.s3_fall    <= (ecnt == 3'h1);
        cyc.cycle_done <= (ecnt == 3'h2);
        if ((ecnt == 3'h0 || ecnt == 3'h3) && cyc_start === 1'b1) ecnt <= 3'h1;
        else if (ecnt == 3'h3) ecnt <= 3'h0;
        else if (ecnt != 3'h0) ecnt <= ecnt + 3'h1;
        ack_q <= ack_n;
        if (ack_q === 1'b1 && ack_n === 1'b0) n_ack <= n_ack + 1;
        if (bclr_n === 1'b0) bclr_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            wrap_up();
        end
    end

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input bit b);
        @(posedge pclk);
        if (b) burst_go <= 1'b1;
        else pulse_go <= 1'b1;
        @(posedge pclk);
        burst_go <= 1'b0;
        pulse_go <= 1'b0;
    endtask

    // Let traffic finish: bus request gone and engine idle for a while
    task automatic settle();
        int k;
        k = 0;
        while (k < 30) begin
            @(posedge pclk);
            if (mb_req === 1'b0 && ecnt == 3'h0 && req_n === 1'b1) k++;
            else k = 0;
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, derq_pkg::CHAN_MODE_OFF, 32'h0);
        chk_word("mode reset", derq_pkg::CHAN_MODE_RST, rd);
        apb(1'b0, derq_pkg::CHAN_CONFIG_OFF, 32'h0);
        chk_word("config reset", derq_pkg::CHAN_CONFIG_RST, rd);
        apb(1'b1, derq_pkg::ARB_CTRL_OFF, 32'hffff_ffff);
        apb(1'b0, derq_pkg::ARB_CTRL_OFF, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        chk_word("idle lines", 32'h7, {29'h0, ack_n, bclr_n, breq_n});
        $display("test reset done");
        // Steal mode without start bit: request ignored
        apb(1'b1, derq_pkg::CHAN_CONFIG_OFF, 32'h0000_1235);
        apb(1'b1, derq_pkg::CHAN_MODE_OFF, 32'h0000_001c);
        pulse(1'b0);
        settle();
        chk_cnt("acks unstarted", 0, n_ack);
        $display("test start gate done");
        // Two edges while an external master holds the bus: one operand only
        arb.ext_master_req <= 1'b1;
        apb(1'b1, derq_pkg::CHAN_MODE_OFF, 32'h0000_001d);
        pulse(1'b0);
        repeat (4) @(posedge pclk);
        pulse(1'b0);
        repeat (6) @(posedge pclk);
        chk_cnt("acks blocked", 0, n_ack);
        arb.ext_master_req <= 1'b0;
        settle();
        chk_cnt("acks steal", 1, n_ack);
        chk_word("bclr steal", 32'h1, {31'h0, bclr_seen});
        $display("test cycle steal done");
        // Interrupt level above mask holds the channel off, synchronizer on
        apb(1'b1, derq_pkg::CHAN_MODE_OFF, 32'h0000_001b);
        arb.int_level <= 3'h7;
        pulse(1'b0);
        repeat (40) @(posedge pclk);
        chk_cnt("acks masked", 1, n_ack);
        arb.int_level <= 3'h3;
        settle();
        chk_cnt("acks unmasked", 2, n_ack);
        $display("test interrupt gate done");
        // Higher-priority internal master wins, threshold equal to ID keeps clear high
        apb(1'b1, derq_pkg::CHAN_CONFIG_OFF, 32'h0000_1535);
        apb(1'b1, derq_pkg::CHAN_MODE_OFF, 32'h0000_001d);
        bclr_seen <= 1'b0;
        arb.other_req <= 1'b1;
        arb.other_id  <= 3'h7;
        pulse(1'b0);
        repeat (30) @(posedge pclk);
        chk_cnt("acks outranked", 2, n_ack);
        arb.other_req <= 1'b0;
        settle();
        chk_cnt("acks after other", 3, n_ack);
        chk_word("bclr threshold", 32'h0, {31'h0, bclr_seen});
        $display("test priority done");
        // Burst: peripheral negates after three acks; at most one extra cycle
        apb(1'b1, derq_pkg::CHAN_MODE_OFF, 32'h0000_0015);
        n_ack <= 0;
        pulse(1'b1);
        settle();
        chk_cnt("burst acks", 4, n_ack);
        rd = n_ack;
        repeat (40) @(posedge pclk);
        chk_cnt("burst stopped", int'(rd), n_ack);
        chk_word("burst lines", 32'h7, {29'h0, ack_n, bclr_n, breq_n});
        $display("test burst done");
        wrap_up();
    end
endmodule

// file: tb/derq_periph.sv
`timescale 1ns/100ps
// Peripheral on the far side: level burst requester or pulsed cycle-steal requester
module derq_periph #(
    parameter int PULSE_CLKS = 2
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ack_n,
    input  wire logic       burst_go,
    input  wire logic       pulse_go,
    input  wire logic [3:0] burst_len,
    output logic            req_n
);
    logic       ack_q;
    logic       bursting;
    logic [3:0] acks;
    int         pc;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_n    <= 1'b1;
            ack_q    <= 1'b1;
            bursting <= 1'b0;
            acks     <= 4'h0;
            pc       <= 0;
        end else begin
            ack_q <= ack_n;
            if (burst_go) begin
                bursting <= 1'b1;
                acks     <= 4'h0;
                req_n    <= 1'b0;
            end else if (bursting && ack_q && !ack_n) begin
                // Negate no later than the cycle end, as soon as the ack is seen
                if (acks + 4'h1 == burst_len) begin
                    req_n    <= 1'b1;
                    bursting <= 1'b0;
                end
                acks <= acks + 4'h1;
            end else if (pulse_go) begin
                // Pulse long enough to pass the synchronizer
                req_n <= 1'b0;
                pc    <= PULSE_CLKS;
            end else if (pc > 1) begin
                pc <= pc - 1;
            end else if (pc == 1) begin
                pc    <= 0;
                req_n <= 1'b1;
            end
        end
    end
endmodule
